// file: rtl/vrsm_pkg.sv
// Constants, field layouts and carrier types of the vector and reset source map
package vrsm_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_SLOTS = 6;

  // Vector slots: number n holds its address at VEC_TOP - 2*n and the byte after it
  localparam logic [15:0] VEC_TOP = 16'hdffe;
  localparam logic [2:0] VNUM_RESET = 3'h0;
  localparam logic [2:0] VNUM_SWI = 3'h1;
  localparam logic [2:0] VNUM_RESERVED = 3'h2;
  localparam logic [2:0] VNUM_LOW_VOLTAGE = 3'h3;
  localparam logic [2:0] VNUM_WAKEUP = 3'h4;
  localparam logic [2:0] VNUM_CHANNEL0 = 3'h5;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_WAKE_INTERVAL = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_RESET_INTERVAL = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h03;
  localparam logic [ADDR_W-1:0] OFS_RESET_CAUSE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h05;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h06;
  localparam logic [ADDR_W-1:0] OFS_VEC_STATE = 8'h07;

  localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
  localparam logic [5:0] INTERVAL_RST = 6'h00;
  localparam logic [DATA_W-1:0] MASK_RST = 8'h00;

  // Flag bits (write one to clear)
  localparam int unsigned FLAG_CH0 = 0;
  localparam int unsigned FLAG_WAKE = 1;
  localparam int unsigned FLAG_LOWV = 2;
  localparam int unsigned FLAG_PERIODIC = 3;

  // Reset cause bits (write one to clear)
  localparam int unsigned CAUSE_POR = 0;
  localparam int unsigned CAUSE_PERIODIC = 1;
  localparam int unsigned CAUSE_WATCHDOG = 2;
  localparam int unsigned CAUSE_LOWV = 3;
  localparam int unsigned CAUSE_TEMP = 4;
  localparam int unsigned CAUSE_OPCODE = 5;
  localparam int unsigned CAUSE_ADDRESS = 6;

  // Interrupt status bits (cleared by reading)
  localparam int unsigned ST_CH0 = 0;
  localparam int unsigned ST_WAKE = 1;
  localparam int unsigned ST_LOWV = 2;
  localparam int unsigned ST_SWI = 3;
  localparam int unsigned ST_RESET = 4;
  localparam int unsigned ST_FETCH = 5;

  typedef struct packed {
    logic [1:0] spare;
    logic       watchdog_enable;
    logic       temp_restart_enable;
    logic       low_voltage_reset_enable;
    logic       low_voltage_detect_enable;
    logic       low_voltage_irq_enable;
    logic       channel0_irq_enable;
  } vrsm_ctrl_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] num;
    logic [15:0] addr;
  } vrsm_vector_t;

  typedef enum logic [1:0] {
    VS_IDLE  = 2'b00,
    VS_OFFER = 2'b01,
    VS_TAKEN = 2'b11
  } vrsm_state_t;

endpackage : vrsm_pkg

// file: rtl/vrsm_sticky.sv
// Bank of sticky flags in which a set outweighs a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module vrsm_sticky #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clear,
  output var  logic [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (reset) begin
          q[i] <= 1'b0;
        end else if (set[i]) begin
          q[i] <= 1'b1;
        end else if (clear[i]) begin
          q[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule // vrsm_sticky
`default_nettype wire

// file: rtl/vrsm_arbiter.sv
// Fixed-priority choice of the pending vector slot and its address
`timescale 1ns/1ps
`default_nettype none
module vrsm_arbiter
  import vrsm_pkg::*;
(
  input  wire logic [NUM_SLOTS-1:0] pending,
  output var  vrsm_vector_t         best
);

  function automatic logic [2:0] lowest_set(input logic [NUM_SLOTS-1:0] p);
    logic [2:0] n;
    n = 3'h0;
    for (int k = NUM_SLOTS - 1; k >= 0; k--) begin
      if (p[k]) begin
        n = 3'(k);
      end
    end
    return n;
  endfunction

  function automatic logic [15:0] slot_addr(input logic [2:0] n);
    return VEC_TOP - {12'h000, n, 1'b0};
  endfunction

  always_comb begin
    best.valid = |pending;
    best.num   = lowest_set(pending);
    best.addr  = slot_addr(best.num);
  end

endmodule // vrsm_arbiter
`default_nettype wire

// file: rtl/vrsm_top.sv
// Interrupt and reset vector source map with register file and vector handshake
`timescale 1ns/1ps
`default_nettype none
module vrsm_top
  import vrsm_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RESET,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output var  logic [DATA_W-1:0] RDATA,
  input  wire logic              CH0_EVENT,
  input  wire logic              WAKEUP_ELAPSED,
  input  wire logic              SUPPLY_LOW,
  input  wire logic              PERIODIC_RESET_ELAPSED,
  input  wire logic              WATCHDOG_TIMEOUT,
  input  wire logic              TEMP_BELOW_RESTART,
  input  wire logic              ILLEGAL_OPCODE,
  input  wire logic              ILLEGAL_ADDRESS,
  input  wire logic              SWI_EXECUTED,
  input  wire logic              VEC_ACK,
  output logic                   VEC_REQ,
  output var  logic [2:0]        VEC_NUM,
  output var  logic [15:0]       VEC_ADDR,
  output var  logic              SYS_RESET_REQ,
  output var  logic [5:0]        WAKEUP_INTERVAL,
  output var  logic [5:0]        PERIODIC_RESET_INTERVAL,
  output logic                   WATCHDOG_ENABLE,
  output logic                   LOW_VOLTAGE_DETECT_ENABLE,
  output logic                   IRQ
);

  vrsm_ctrl_t               ctrl;
  logic [5:0]               wakeup_interval_select;
  logic [5:0]               periodic_reset_interval;
  logic [DATA_W-1:0]        irq_mask;
  logic [3:0]               flags;
  logic [6:0]               reset_cause;
  logic [DATA_W-1:0]        irq_status;
  logic                     supply_low_q;
  logic                     temp_below_q;
  logic                     reset_pending;
  logic                     swi_pending;
  vrsm_state_t              state;
  vrsm_state_t              next_state;
  vrsm_vector_t             best;
  logic [NUM_SLOTS-1:0]     pending;

  logic                     wr_flags;
  logic                     wr_cause;
  logic                     rd_status;
  logic                     supply_fall;
  logic                     temp_fall;
  logic                     lowv_irq_event;
  logic                     lowv_reset_event;
  logic                     watchdog_event;
  logic                     temp_event;
  logic                     any_reset_event;
  logic                     ack_taken;
  logic [3:0]               flag_set;
  logic [3:0]               flag_clear;
  logic [6:0]               cause_set;
  logic [6:0]               cause_clear;
  logic [DATA_W-1:0]        status_set;
  logic [DATA_W-1:0]        status_clear;

  // Bus decode
  assign wr_flags  = WR && (ADDR == OFS_FLAGS);
  assign wr_cause  = WR && (ADDR == OFS_RESET_CAUSE);
  assign rd_status = RD && (ADDR == OFS_IRQ_STATUS);

  // Software-written configuration
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl <= vrsm_ctrl_t'(CTRL_RST);
    end else if (WR && (ADDR == OFS_CTRL)) begin
      ctrl <= vrsm_ctrl_t'(WDATA);
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      wakeup_interval_select <= INTERVAL_RST;
    end else if (WR && (ADDR == OFS_WAKE_INTERVAL)) begin
      wakeup_interval_select <= WDATA[5:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      periodic_reset_interval <= INTERVAL_RST;
    end else if (WR && (ADDR == OFS_RESET_INTERVAL)) begin
      periodic_reset_interval <= WDATA[5:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      irq_mask <= MASK_RST;
    end else if (WR && (ADDR == OFS_IRQ_MASK)) begin
      irq_mask <= WDATA;
    end
  end

  assign WATCHDOG_ENABLE           = ctrl.watchdog_enable;
  assign LOW_VOLTAGE_DETECT_ENABLE = ctrl.low_voltage_detect_enable;

  // Wakeup unit reads its intervals from here; registered copies keep them glitch free
  always_ff @(posedge CLK) begin
    if (RESET) begin
      WAKEUP_INTERVAL         <= INTERVAL_RST;
      PERIODIC_RESET_INTERVAL <= INTERVAL_RST;
    end else begin
      WAKEUP_INTERVAL         <= wakeup_interval_select;
      PERIODIC_RESET_INTERVAL <= periodic_reset_interval;
    end
  end

  // Level sources are acted on at their falling-below edge only
  always_ff @(posedge CLK) begin
    if (RESET) begin
      supply_low_q <= 1'b0;
      temp_below_q <= 1'b0;
    end else begin
      supply_low_q <= SUPPLY_LOW;
      temp_below_q <= TEMP_BELOW_RESTART;
    end
  end

  assign supply_fall = SUPPLY_LOW && !supply_low_q;
  assign temp_fall   = TEMP_BELOW_RESTART && !temp_below_q;

  assign lowv_irq_event = supply_fall && ctrl.low_voltage_detect_enable
                          && ctrl.low_voltage_irq_enable
                          && !ctrl.low_voltage_reset_enable;
  assign lowv_reset_event = supply_fall && ctrl.low_voltage_detect_enable
                            && ctrl.low_voltage_reset_enable;
  assign watchdog_event = WATCHDOG_TIMEOUT && ctrl.watchdog_enable;
  assign temp_event     = temp_fall && ctrl.temp_restart_enable;

  assign any_reset_event = PERIODIC_RESET_ELAPSED || watchdog_event || lowv_reset_event
                           || temp_event || ILLEGAL_OPCODE || ILLEGAL_ADDRESS;

  // Source flags
  always_comb begin
    flag_set                = 4'h0;
    flag_set[FLAG_CH0]      = CH0_EVENT;
    flag_set[FLAG_WAKE]     = WAKEUP_ELAPSED;
    flag_set[FLAG_LOWV]     = lowv_irq_event;
    flag_set[FLAG_PERIODIC] = PERIODIC_RESET_ELAPSED;
    flag_clear              = wr_flags ? WDATA[3:0] : 4'h0;
  end

  vrsm_sticky #(
    .W (4)
  ) u_flags (
    .clk   (CLK),
    .reset (RESET),
    .set   (flag_set),
    .clear (flag_clear),
    .q     (flags)
  );

  // Reset cause record; power-on is recorded by the reset value below
  always_comb begin
    cause_set                 = 7'h00;
    cause_set[CAUSE_PERIODIC] = PERIODIC_RESET_ELAPSED;
    cause_set[CAUSE_WATCHDOG] = watchdog_event;
    cause_set[CAUSE_LOWV]     = lowv_reset_event;
    cause_set[CAUSE_TEMP]     = temp_event;
    cause_set[CAUSE_OPCODE]   = ILLEGAL_OPCODE;
    cause_set[CAUSE_ADDRESS]  = ILLEGAL_ADDRESS;
    cause_clear               = wr_cause ? WDATA[6:0] : 7'h00;
  end

  logic [6:0] cause_bank;
  logic       por_seen;

  vrsm_sticky #(
    .W (7)
  ) u_cause (
    .clk   (CLK),
    .reset (RESET),
    .set   (cause_set),
    .clear (cause_clear),
    .q     (cause_bank)
  );

  always_ff @(posedge CLK) begin
    if (RESET) begin
      por_seen <= 1'b1;
    end else if (wr_cause && WDATA[CAUSE_POR]) begin
      por_seen <= 1'b0;
    end
  end

  always_comb begin
    reset_cause            = cause_bank;
    reset_cause[CAUSE_POR] = por_seen;
  end

  // Vector requests
  always_ff @(posedge CLK) begin
    if (RESET) begin
      reset_pending <= 1'b1;
    end else if (any_reset_event) begin
      reset_pending <= 1'b1;
    end else if (ack_taken && VEC_NUM == VNUM_RESET) begin
      reset_pending <= 1'b0;
    end
  end

  // A reset abandons an unserved software interrupt
  always_ff @(posedge CLK) begin
    if (RESET) begin
      swi_pending <= 1'b0;
    end else if (any_reset_event) begin
      swi_pending <= 1'b0;
    end else if (SWI_EXECUTED) begin
      swi_pending <= 1'b1;
    end else if (ack_taken && VEC_NUM == VNUM_SWI) begin
      swi_pending <= 1'b0;
    end
  end

  always_comb begin
    pending                   = '0;
    pending[VNUM_RESET]       = reset_pending;
    pending[VNUM_SWI]         = swi_pending;
    pending[VNUM_RESERVED]    = 1'b0;
    pending[VNUM_LOW_VOLTAGE] = flags[FLAG_LOWV] && ctrl.low_voltage_irq_enable;
    pending[VNUM_WAKEUP]      = flags[FLAG_WAKE];
    pending[VNUM_CHANNEL0]    = flags[FLAG_CH0] && ctrl.channel0_irq_enable;
  end

  vrsm_arbiter u_arbiter (
    .pending (pending),
    .best    (best)
  );

  // Shown vector follows the winner every cycle, so a late reset still overtakes
  always_ff @(posedge CLK) begin
    if (RESET) begin
      VEC_NUM  <= VNUM_RESET;
      VEC_ADDR <= VEC_TOP;
    end else begin
      VEC_NUM  <= best.num;
      VEC_ADDR <= best.addr;
    end
  end

  // Offer handshake toward the CPU fetch
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state <= VS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      VS_IDLE: begin
        if (best.valid) begin
          next_state = VS_OFFER;
        end
      end
      VS_OFFER: begin
        if (VEC_ACK) begin
          next_state = VS_TAKEN;
        end else if (!best.valid) begin
          next_state = VS_IDLE;
        end
      end
      VS_TAKEN: begin
        next_state = VS_IDLE;
      end
      default: begin
        next_state = VS_IDLE;
      end
    endcase
  end

  // Request drops the cycle after the winner vanishes; an ack then is ignored
  assign VEC_REQ   = (state == VS_OFFER);
  assign ack_taken = VEC_REQ && VEC_ACK;

  // System reset request pulse
  always_ff @(posedge CLK) begin
    if (RESET) begin
      SYS_RESET_REQ <= 1'b0;
    end else begin
      SYS_RESET_REQ <= any_reset_event;
    end
  end

  // Interrupt status, cleared by a read; a set in the read cycle survives
  always_comb begin
    status_set           = '0;
    status_set[ST_CH0]   = CH0_EVENT;
    status_set[ST_WAKE]  = WAKEUP_ELAPSED;
    status_set[ST_LOWV]  = lowv_irq_event;
    status_set[ST_SWI]   = SWI_EXECUTED;
    status_set[ST_RESET] = any_reset_event;
    status_set[ST_FETCH] = ack_taken;
    status_clear         = rd_status ? {DATA_W{1'b1}} : '0;
  end

  vrsm_sticky #(
    .W (DATA_W)
  ) u_status (
    .clk   (CLK),
    .reset (RESET),
    .set   (status_set),
    .clear (status_clear),
    .q     (irq_status)
  );

  assign IRQ = |(irq_status & irq_mask);

  // Read data, valid the cycle after the strobe only
  always_ff @(posedge CLK) begin
    if (RESET) begin
      RDATA <= '0;
    end else if (RD) begin
      case (ADDR)
        OFS_CTRL:           RDATA <= ctrl;
        OFS_WAKE_INTERVAL:  RDATA <= {2'b00, wakeup_interval_select};
        OFS_RESET_INTERVAL: RDATA <= {2'b00, periodic_reset_interval};
        OFS_FLAGS:          RDATA <= {4'h0, flags};
        OFS_RESET_CAUSE:    RDATA <= {1'b0, reset_cause};
        OFS_IRQ_STATUS:     RDATA <= irq_status;
        OFS_IRQ_MASK:       RDATA <= irq_mask;
        OFS_VEC_STATE:      RDATA <= {3'b000, VEC_REQ, best.valid, VEC_NUM};
        default:            RDATA <= '0;
      endcase
    end else begin
      RDATA <= '0;
    end
  end

endmodule // vrsm_top
`default_nettype wire

// file: sim/vrsm_assertions.sv
// Concurrent checks on the ports of the vector and reset source map
`timescale 1ns/1ps
`default_nettype none
module vrsm_checker
  import vrsm_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RESET,
  input wire logic        SUPPLY_LOW,
  input wire logic        PERIODIC_RESET_ELAPSED,
  input wire logic        WATCHDOG_TIMEOUT,
  input wire logic        TEMP_BELOW_RESTART,
  input wire logic        ILLEGAL_OPCODE,
  input wire logic        ILLEGAL_ADDRESS,
  input wire logic        SWI_EXECUTED,
  input wire logic        VEC_ACK,
  input wire logic        VEC_REQ,
  input wire logic [2:0]  VEC_NUM,
  input wire logic [15:0] VEC_ADDR,
  input wire logic        SYS_RESET_REQ,
  input wire logic        WATCHDOG_ENABLE,
  input wire logic        LOW_VOLTAGE_DETECT_ENABLE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  // Sources that reset with no enable bit in front of them
  wire logic bare_rst = PERIODIC_RESET_ELAPSED | ILLEGAL_OPCODE | ILLEGAL_ADDRESS;

  addr_map_a: assert property (VEC_ADDR == VEC_TOP - {12'h000, VEC_NUM, 1'b0})
    else $error("vector address does not match its slot");
  no_resv_a: assert property (VEC_NUM != VNUM_RESERVED)
    else $error("reserved slot offered");
  reset_pulse_a: assert property (bare_rst || (WATCHDOG_TIMEOUT && WATCHDOG_ENABLE) |=> SYS_RESET_REQ)
    else $error("reset source gave no reset request");
  wdog_off_a: assert property (WATCHDOG_TIMEOUT && !WATCHDOG_ENABLE && !bare_rst && !SUPPLY_LOW
    && !TEMP_BELOW_RESTART |=> !SYS_RESET_REQ)
    else $error("disabled watchdog caused a reset");
  lowv_off_a: assert property ($rose(SUPPLY_LOW) && !LOW_VOLTAGE_DETECT_ENABLE && !bare_rst
    && !WATCHDOG_TIMEOUT && !TEMP_BELOW_RESTART |=> !SYS_RESET_REQ)
    else $error("low voltage reset with detection off");
  reset_vec_a: assert property (SYS_RESET_REQ |=> VEC_NUM == VNUM_RESET)
    else $error("reset request not shown as vector 0");
  swi_req_a: assert property (SWI_EXECUTED |-> ##[2:4] (VEC_REQ && VEC_NUM <= VNUM_SWI))
    else $error("software interrupt not offered in time");
  ack_drop_a: assert property (VEC_REQ && VEC_ACK |=> !VEC_REQ [*2])
    else $error("offer not withdrawn after take");

  cover property (VEC_REQ && VEC_ACK && VEC_NUM == VNUM_SWI);
  cover property (VEC_REQ && VEC_ACK && VEC_NUM == VNUM_CHANNEL0);
  cover property (SYS_RESET_REQ);
endmodule // vrsm_checker

bind vrsm_top vrsm_checker i_chk (.CLK, .RESET, .SUPPLY_LOW, .PERIODIC_RESET_ELAPSED,
  .WATCHDOG_TIMEOUT, .TEMP_BELOW_RESTART, .ILLEGAL_OPCODE, .ILLEGAL_ADDRESS, .SWI_EXECUTED,
  .VEC_ACK, .VEC_REQ, .VEC_NUM, .VEC_ADDR, .SYS_RESET_REQ, .WATCHDOG_ENABLE,
  .LOW_VOLTAGE_DETECT_ENABLE);
`default_nettype wire

// file: sim/vrsm_cpu_model.sv
// Behavioural CPU core that takes the offered vectors
`timescale 1ns/1ps
`default_nettype none
module vrsm_cpu_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        en,
  input  wire logic [3:0]  delay,
  input  wire logic        vec_req,
  input  wire logic [2:0]  vec_num,
  input  wire logic [15:0] vec_addr,
  output var  logic        vec_ack,
  output var  logic [2:0]  took_num,
  output var  logic [15:0] took_addr,
  output var  int unsigned took_count
);
  logic [3:0] wait_cnt;

  always_ff @(posedge clk) begin
    if (reset) begin
      vec_ack <= 1'b0;
      wait_cnt <= 4'h0;
      took_num <= 3'h0;
      took_addr <= 16'h0000;
      took_count <= 0;
    end else if (vec_ack && vec_req) begin
      vec_ack <= 1'b0;
      wait_cnt <= 4'h0;
      took_num <= vec_num;
      took_addr <= vec_addr;
      took_count <= took_count + 1;
    end else if (vec_ack) begin
      // Offer withdrawn: a stale ack would grab the next vector early
      vec_ack <= 1'b0;
    end else if (en && vec_req) begin
      if (wait_cnt >= delay) begin
        vec_ack <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule // vrsm_cpu_model
`default_nettype wire

// file: sim/vrsm_top_tb.sv
// Self-checking bench for the vector and reset source map
`timescale 1ns/1ps
`default_nettype none
`define CHECK_EQ(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module vrsm_top_tb;
  import vrsm_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic [8:0]  src = 9'h000;
  logic        en = 1'b0;
  logic [3:0]  delay = 4'h0;
  logic [7:0]  rdata;
  logic        vec_ack;
  logic        vec_req;
  logic [2:0]  vec_num;
  logic [15:0] vec_addr;
  logic [5:0]  wake_iv;
  logic [5:0]  rst_iv;
  logic        irq;
  logic [2:0]  took_num;
  logic [15:0] took_addr;
  int unsigned took_count;
  int unsigned bad_count = 0;
  int unsigned num_checks = 0;
  // Source order: ch0, wakeup, supply, periodic, watchdog, temp, opcode, address, swi
  int unsigned rs_src[6] = '{3, 6, 7, 4, 2, 5};
  int unsigned rs_bit[6] = '{CAUSE_PERIODIC, CAUSE_OPCODE, CAUSE_ADDRESS, CAUSE_WATCHDOG,
                             CAUSE_LOWV, CAUSE_TEMP};

  always #2 clk = ~clk;

  vrsm_top i_dut (.CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .CH0_EVENT(src[0]), .WAKEUP_ELAPSED(src[1]), .SUPPLY_LOW(src[2]),
    .PERIODIC_RESET_ELAPSED(src[3]), .WATCHDOG_TIMEOUT(src[4]), .TEMP_BELOW_RESTART(src[5]),
    .ILLEGAL_OPCODE(src[6]), .ILLEGAL_ADDRESS(src[7]), .SWI_EXECUTED(src[8]),
    .VEC_ACK(vec_ack), .VEC_REQ(vec_req), .VEC_NUM(vec_num), .VEC_ADDR(vec_addr),
    .SYS_RESET_REQ(), .WAKEUP_INTERVAL(wake_iv), .PERIODIC_RESET_INTERVAL(rst_iv),
    .WATCHDOG_ENABLE(), .LOW_VOLTAGE_DETECT_ENABLE(), .IRQ(irq));

  vrsm_cpu_model i_cpu (.clk(clk), .reset(reset), .en(en), .delay(delay), .vec_req(vec_req),
    .vec_num(vec_num), .vec_addr(vec_addr), .vec_ack(vec_ack), .took_num(took_num),
    .took_addr(took_addr), .took_count(took_count));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    `CHECK_EQ(nm, exp, rdata)
  endtask

  task automatic pulse(input int unsigned i);
    @(posedge clk);
    src[i] <= 1'b1;
    @(posedge clk);
    src[i] <= 1'b0;
  endtask

  task automatic take_one(input logic [2:0] n);
    int unsigned c0;
    c0 = took_count;
    // Edge first, so back-to-back calls never drive en twice in one step
    @(posedge clk);
    en <= 1'b1;
    for (int k = 0; k < 60 && took_count == c0; k++) begin
      @(posedge clk);
      #1;
    end
    en <= 1'b0;
    if (took_count == c0) begin
      bad_count++;
      $display("[FAIL] vector take expected %h seen none", n);
      report_and_stop();
    end else begin
      `CHECK_EQ("vector number", n, took_num)
      `CHECK_EQ("vector address", VEC_TOP - {12'h000, n, 1'b0}, took_addr)
    end
  endtask

  initial begin
    #200000;
    bad_count++;
    $display("[FAIL] run length expected finish seen timeout");
    report_and_stop();
  end

  initial begin
    int unsigned c;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    take_one(VNUM_RESET);
    rchk(OFS_RESET_CAUSE, 8'h01, "power-on cause");
    rchk(OFS_CTRL, CTRL_RST, "ctrl reset value");
    rchk(8'h20, 8'h00, "unmapped read");
    wr(8'h20, 8'hff);
    wr(OFS_WAKE_INTERVAL, 8'h3f);
    wr(OFS_RESET_INTERVAL, 8'h2a);
    rchk(OFS_CTRL, 8'h00, "ctrl after unmapped write");
    `CHECK_EQ("wakeup interval", 6'h3f, wake_iv)
    `CHECK_EQ("reset interval", 6'h2a, rst_iv)
    // Irq enable on too: with reset enable set the supply drop must still reset
    wr(OFS_CTRL, 8'h3e);
    for (int i = 0; i < 6; i++) begin
      wr(OFS_RESET_CAUSE, 8'hff);
      pulse(rs_src[i]);
      take_one(VNUM_RESET);
      rchk(OFS_RESET_CAUSE, 8'h01 << rs_bit[i], "reset cause");
    end
    rchk(OFS_FLAGS, 8'h08, "flags after resets");
    wr(OFS_FLAGS, 8'hff);
    wr(OFS_CTRL, 8'h00);
    c = took_count;
    en <= 1'b1;
    pulse(4);
    pulse(5);
    pulse(2);
    repeat (8) @(posedge clk);
    en <= 1'b0;
    `CHECK_EQ("takes with enables off", c, took_count)
    // Reset events and vector fetches since power-on, never read so far
    rchk(OFS_IRQ_STATUS, 8'h30, "status after reset events");
    rchk(OFS_IRQ_STATUS, 8'h00, "status after reset events read"); 
    wr(OFS_IRQ_MASK, 8'h00);
    wr(OFS_CTRL, 8'h07);
    pulse(0);
    pulse(1);
    pulse(2);
    pulse(8);
    rchk(OFS_VEC_STATE, 8'h19, "swi outranks others");
    `CHECK_EQ("irq while masked", 1'b0, irq)
    wr(OFS_IRQ_MASK, 8'h08);
    rchk(OFS_IRQ_MASK, 8'h08, "mask readback");
    `CHECK_EQ("irq unmasked", 1'b1, irq)
    rchk(OFS_IRQ_STATUS, 8'h0f, "irq status");
    `CHECK_EQ("irq after status read", 1'b0, irq)
    rchk(OFS_FLAGS, 8'h07, "flags");
    delay <= 4'h3;
    take_one(VNUM_SWI);
    take_one(VNUM_LOW_VOLTAGE);
    repeat (3) @(posedge clk);
    rchk(OFS_VEC_STATE, 8'h1b, "low voltage still asks");
    wr(OFS_FLAGS, 8'h04);
    take_one(VNUM_WAKEUP);
    wr(OFS_FLAGS, 8'h02);
    take_one(VNUM_CHANNEL0);
    // Channel 0 still asks; a reset source must overtake it
    pulse(6);
    take_one(VNUM_RESET);
    wr(OFS_FLAGS, 8'h01);
    repeat (3) @(posedge clk);
    rchk(OFS_VEC_STATE, 8'h00, "all served");
    report_and_stop();
  end
endmodule // vrsm_top_tb
`default_nettype wire
